// ==== bench/rsd_upstream_model.sv ====
/*
 * Upstream source: sends one all-zero code block per go pulse, with an
 * optional error symbol and an optional erased symbol.
 * Assumes stall is raised only while a block is being sent.
 */
`timescale 1ns/1ns
module rsd_upstream_model (
    input  wire logic          clk,     // Sample clock
    input  wire logic          go,      // Start one block
    input  wire logic          stall,   // Hold symbol, enable low
    input  wire rsd_pkg::sym_t blk_n,   // Block length
    input  wire rsd_pkg::sym_t err_pos, // Error position, ff for none
    input  wire rsd_pkg::sym_t err_val, // Error value
    input  wire rsd_pkg::sym_t ers_pos, // Erased position, ff for none
    output logic               en,      // Enable
    output rsd_pkg::sym_t      data_in, // Symbol
    output logic               sync,    // Start marker
    output logic               erase,   // Erasure flag
    output rsd_pkg::sym_t      n_in     // Length
);
    rsd_pkg::sym_t idx = 8'h00;
    logic          busy = 1'b0;
    initial {en, data_in, sync, erase, n_in} = {1'b1, 8'h00, 2'b00, 8'h00};
    always @(posedge clk) begin
        en <= !stall;
        if (stall) begin
            // Symbol stands while enable is low
        end else if (go && !busy) begin
            busy    <= 1'b1;
            idx     <= 8'h01;
            sync    <= 1'b1;
            n_in    <= blk_n;
            data_in <= 8'h00;
            erase   <= 1'b0;
        end else if (busy) begin
            sync    <= 1'b0;
            data_in <= (idx == err_pos || idx == ers_pos) ? err_val : 8'h00;
            erase   <= (idx == ers_pos);
            idx     <= idx + 8'h01;
            busy    <= (idx != blk_n - 8'h01);
        end else begin
            // Junk between blocks must be dropped
            sync    <= 1'b0;
            erase   <= 1'b0;
            data_in <= data_in + 8'h3b;
            n_in    <= ~n_in;
        end
    end
endmodule : rsd_upstream_model

// ==== bench/test_reed_solomon_block_decoder.sv ====
/*
 * Self-checking bench: zero code blocks, corrected errors and erasures,
 * shortened length, mid-block clear.
 * Assumes the upstream model drives the input stream.
 */
`timescale 1ns/1ns
module test_reed_solomon_block_decoder;
    logic  clk = 0, sys_rst = 1, sync_clear = 0, go = 0, stall = 0, en, sync, erase;
    logic  out_valid, blk_start, blk_end_n, ready, first_ready;
    rsd_pkg::sym_t blk_n = 8'hff, err_pos = 8'hff, err_val = 8'h5a, ers_pos = 8'hff;
    rsd_pkg::sym_t data_in, n_in, data_out, data_del;
    rsd_pkg::blk_status_s status;
    int    fail_count = 0, checked = 0, cyc = 0, nout;
    rsd_upstream_model up (.clk(clk), .go(go), .stall(stall), .blk_n(blk_n), .err_pos(err_pos),
        .err_val(err_val), .ers_pos(ers_pos), .en(en), .data_in(data_in),
        .sync(sync), .erase(erase), .n_in(n_in));
    reed_solomon_block_decoder DUT (.clk(clk), .sys_rst(sys_rst), .sync_clear(sync_clear),
        .en(en), .data_in(data_in), .sync(sync), .erase(erase), .n_in(n_in),
        .data_out(data_out), .data_del(data_del), .out_valid(out_valid),
        .blk_start(blk_start), .blk_end_n(blk_end_n), .status(status),
        .ready(ready), .first_ready(first_ready));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task cmp(string what, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (exp !== got) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task run_block(string name, rsd_pkg::sym_t n, rsd_pkg::sym_t p, rsd_pkg::sym_t e,
                   rsd_pkg::blk_status_s exp);
        nout = 0;
        @(posedge clk);
        {blk_n, err_pos, ers_pos, go} <= {n, p, e, 1'b1};
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        stall <= 1'b1;
        @(posedge clk);
        stall <= 1'b0;
        do @(negedge clk); while (ready !== 1'b0);
        cmp("first_ready", 1'b0, first_ready);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 2000 && nout < n; i++) begin
            @(negedge clk);
            if (out_valid === 1'b1) begin
                cmp("data_out", 16'h0000, data_out);
                cmp("blk_start", nout == 0, blk_start);
                cmp("blk_end_n", nout != n - 1, blk_end_n);
                if (nout == n - 1) cmp("status", exp, status);
                cmp("data_del", (nout == p || nout == e) ? err_val : 8'h00, data_del);
                nout++;
            end
        end
        cmp("symbols", n, nout);
        $display("test %s done", name);
    endtask : run_block
    task clear_mid;
        @(posedge clk);
        {blk_n, err_pos, ers_pos, go} <= {8'hff, 8'hff, 8'hff, 1'b1};
        repeat (20) @(posedge clk);
        {go, sync_clear} <= 2'b01;
        @(posedge clk);
        sync_clear <= 1'b0;
        @(negedge clk);
        cmp("ready", 1'b1, ready);
        cmp("first_ready", 1'b1, first_ready);
        repeat (300) @(posedge clk);
        $display("test clear_mid done");
    endtask : clear_mid
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        run_block("clean", 8'hff, 8'hff, 8'hff, '0);
        run_block("err_ers", 8'hff, 8'h05, 8'h09, '{1'b1, 5'h01, 1'b0, 8'h01});
        clear_mid();
        run_block("short", 8'h14, 8'h03, 8'h07, '{1'b1, 5'h01, 1'b0, 8'h01});
        tally_and_finish();
    end
endmodule : test_reed_solomon_block_decoder

// ==== src/reed_solomon_block_decoder.sv ====
/*
 * Reed-Solomon block decoder: syndromes on arrival, erasure-seeded
 * inversionless Berlekamp-Massey, evaluator, then Chien search and Forney
 * correction while the stored block is read out.
 * Assumes upstream logic on the same clock, one symbol per enabled cycle.
 */
`timescale 1ns/1ns
`include "rsd_defs.svh"

// Function
// (RQ1) Drop symbols until the first start marker
// (RQ2) Ignore start marker while unable to accept
// (RQ3) Upstream holds reset before expecting decoding
// (RQ4) Erase flag marks the accompanying symbol erased
// (RQ5) Sample block length at every block start
// (RQ6) Synchronous clear returns all state to initial
// (RQ7) Output corrected information and parity symbols
// (RQ8) Start flag high on first output symbol
// (RQ9) End flag low on last output symbol
// (RQ10) Error-found flag with last symbol
// (RQ11) Corrected error count with last symbol
// (RQ12) Failure flag with last symbol
// (RQ13) Corrected erasure count with last symbol
// (RQ14) Ready high when a symbol can be taken
// (RQ15) First-ready high when a block can start
// (RQ16) Raw symbol alongside its corrected symbol
// (RQ17) Recover whenever twice errors plus erasures fit
// (RQ18) Preset code shapes selectable
// (RQ19) Channel count; this build decodes one
// (RQ20) Upstream holds symbols for clocks-per-symbol
// (RQ21) Symbol width and code limits respected
// (RQ22) Field polynomial selectable, zero gives default
// (RQ23) Enable low freezes state, outputs and sampling
module reed_solomon_block_decoder (
    input  wire logic                 clk,         // 50 MHz sample clock
    input  wire logic                 sys_rst,     // Synchronous reset, high
    input  wire logic                 sync_clear,  // Optional synchronous clear
    input  wire logic                 en,          // Decoder enable
    input  wire rsd_pkg::sym_t        data_in,     // Received symbol
    input  wire logic                 sync,        // Block start marker
    input  wire logic                 erase,       // Symbol is an erasure
    input  wire rsd_pkg::sym_t        n_in,        // Length of next block
    output rsd_pkg::sym_t             data_out,    // Corrected symbol
    output rsd_pkg::sym_t             data_del,    // Uncorrected symbol
    output logic                      out_valid,   // data_out carries a symbol
    output logic                      blk_start,   // First symbol of block
    output logic                      blk_end_n,   // Low on last symbol
    output rsd_pkg::blk_status_s      status,      // Per-block result
    output logic                      ready,       // Symbol can be taken
    output logic                      first_ready  // New block can start
);
    localparam int            PAR     = rsd_pkg::PAR;
    localparam int            SYM_W   = `RSD_SYM_W;                    // see RQ21
    localparam logic [SYM_W:0] POLY   = (`RSD_POLY_SEL == 9'h000) ?
                                        `RSD_POLY_DEF : `RSD_POLY_SEL;  // see RQ22
    localparam rsd_pkg::sym_t POLY_LO = POLY[SYM_W-1:0];
    localparam rsd_pkg::sym_t ALPHA   = `RSD_ALPHA;
    localparam rsd_pkg::sym_t INV_EXP = 8'hfe;
    localparam rsd_pkg::sym_t N_FIX   = 8'(`RSD_N);                    // see RQ18

    ////////////////////////////////////////////////////////////////////////////
    // Field arithmetic
    function automatic rsd_pkg::sym_t gf_mul(input rsd_pkg::sym_t a,
                                             input rsd_pkg::sym_t b);
        rsd_pkg::sym_t p;
        rsd_pkg::sym_t x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < SYM_W; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = x[SYM_W-1] ? ({x[SYM_W-2:0], 1'b0} ^ POLY_LO) : {x[SYM_W-2:0], 1'b0};
        end
        return p;
    endfunction : gf_mul

    // Square and multiply; with exponent 2^s-2 this is the inverse
    function automatic rsd_pkg::sym_t gf_pow(input rsd_pkg::sym_t b,
                                             input rsd_pkg::sym_t e);
        rsd_pkg::sym_t r;
        r = 8'h01;
        for (int i = SYM_W - 1; i >= 0; i--) begin
            r = gf_mul(r, r);
            if (e[i]) begin
                r = gf_mul(r, b);
            end
        end
        return r;
    endfunction : gf_pow

    localparam rsd_pkg::sym_t ALPHA_INV = gf_pow(ALPHA, INV_EXP);

    ////////////////////////////////////////////////////////////////////////////
    // State and datapath nets
    rsd_pkg::dec_st_s          cur;
    rsd_pkg::dec_st_s          nxt;
    rsd_pkg::sym_t [PAR:0]     bm_lam;
    rsd_pkg::sym_t [PAR:0]     er_lam;
    rsd_pkg::sym_t [PAR:0]     lam_base;
    rsd_pkg::sym_t [PAR:0]     cl_step;
    rsd_pkg::sym_t [PAR:0]     prod;
    rsd_pkg::sym_t [PAR-1:0]   syn_base;
    rsd_pkg::sym_t [PAR-1:0]   syn_upd;
    rsd_pkg::sym_t [PAR-1:0]   co_step;
    rsd_pkg::sym_t             dot;
    rsd_pkg::sym_t             x0;
    rsd_pkg::sym_t             xcur;
    rsd_pkg::sym_t             nlen;
    rsd_pkg::sym_t             lam_val;
    rsd_pkg::sym_t             odd_val;
    rsd_pkg::sym_t             om_val;
    rsd_pkg::sym_t             nerr_n;
    rsd_pkg::sym_t             nera_n;
    logic                      erase_eff;
    logic                      ram_we;
    logic [SYM_W:0]            ram_rd;
    logic                      clr;

    assign erase_eff = erase & `RSD_OPT_ERASE;                         // see RQ4
    assign nlen      = `RSD_OPT_VARN ? n_in : N_FIX;                   // see RQ5
    assign x0        = gf_pow(ALPHA, nlen - 8'h01);
    assign xcur      = (cur.st == rsd_pkg::ST_IDLE) ? x0 : cur.xpos;
    assign ram_we    = en && (((cur.st == rsd_pkg::ST_IDLE) && sync) ||
                              (cur.st == rsd_pkg::ST_RECV));
    assign clr       = sys_rst | (`RSD_OPT_SRST & sync_clear);         // see RQ6

    // Single channel: the whole block shares one store, see RQ19
    rsd_symbol_ram u_ram (
        .clk     (clk),
        .wr_en   (ram_we),
        .wr_addr ((cur.st == rsd_pkg::ST_IDLE) ? 8'h00 : cur.cnt),
        .wr_data ({erase_eff, data_in}),
        .rd_en   (en),
        .rd_addr (cur.cnt),
        .rd_data (ram_rd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Per-coefficient arithmetic
    genvar gi;
    generate
        for (gi = 0; gi <= PAR; gi++) begin : g_coef
            localparam rsd_pkg::sym_t AP = gf_pow(ALPHA, 8'(gi));
            assign lam_base[gi] = (cur.st == rsd_pkg::ST_IDLE) ?
                                  ((gi == 0) ? 8'h01 : 8'h00) : cur.lam[gi];
            assign cl_step[gi]  = gf_mul(cur.cl[gi], AP);
            assign prod[gi]     = (cur.kit >= 8'(gi)) ?
                                  gf_mul(cur.lam[gi], cur.syn[8'(cur.kit - 8'(gi))]) : 8'h00;
            if (gi == 0) begin : g_low
                assign bm_lam[gi] = gf_mul(cur.gam, cur.lam[gi]);
                assign er_lam[gi] = lam_base[gi];
            end else begin : g_high
                assign bm_lam[gi] = gf_mul(cur.gam, cur.lam[gi]) ^ gf_mul(dot, cur.bb[gi-1]);
                assign er_lam[gi] = lam_base[gi] ^ gf_mul(xcur, lam_base[gi-1]);
            end
            if (gi < PAR) begin : g_syn
                assign syn_base[gi] = (cur.st == rsd_pkg::ST_IDLE) ? 8'h00 : cur.syn[gi];
                assign syn_upd[gi]  = gf_mul(syn_base[gi], AP) ^ data_in;
                assign co_step[gi]  = gf_mul(cur.co[gi], AP);
            end
        end
    endgenerate

    // Discrepancy and evaluator share one dot product; Chien sums
    always_comb begin
        dot     = 8'h00;
        lam_val = 8'h00;
        odd_val = 8'h00;
        om_val  = 8'h00;
        for (int i = 0; i <= PAR; i++) begin
            dot     = dot ^ prod[i];
            lam_val = lam_val ^ cur.cl[i];
            if (i % 2 == 1) begin
                odd_val = odd_val ^ cur.cl[i];
            end
            if (i < PAR) begin
                om_val = om_val ^ cur.co[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt    = cur;
        nerr_n = cur.nerr;
        nera_n = cur.nera;
        if (en) begin                                                  // see RQ23
            // Output stage: RAM word meets the registered error value
            nxt.p_vld  = 1'b0;
            nxt.ovalid = cur.p_vld;
            nxt.bstart = cur.p_vld & cur.p_first;                      // see RQ8
            nxt.bend_n = ~(cur.p_vld & cur.p_last);                    // see RQ9
            if (cur.p_vld) begin
                nxt.dout = ram_rd[SYM_W-1:0] ^ cur.p_err;              // see RQ7
                nxt.ddel = `RSD_OPT_DEL ? ram_rd[SYM_W-1:0] : 8'h00;   // see RQ16
                if (cur.p_root && ram_rd[SYM_W]) begin
                    nera_n = cur.nera + 8'h01;
                end else if (cur.p_root) begin
                    nerr_n = cur.nerr + 8'h01;
                end
                nxt.nerr = nerr_n;
                nxt.nera = nera_n;
                if (cur.p_last) begin
                    nxt.stat.err_found = cur.synz | (cur.ers != 8'h00);    // see RQ10
                    nxt.stat.err_cnt   = rsd_pkg::CNT_W'(nerr_n);          // see RQ11
                    nxt.stat.erase_cnt = nera_n;                           // see RQ13
                    // Root count must match locator degree, see RQ17
                    nxt.stat.fail      = (cur.roots != cur.len) ||
                                         (cur.len > 8'(PAR)) ||
                                         (cur.ers > 8'(PAR)) ||
                                         (cur.synz && cur.len == 8'h00);   // see RQ12
                end
            end
            unique case (cur.st)
                rsd_pkg::ST_IDLE: begin
                    // Unmarked symbols fall away here, see RQ1
                    if (sync) begin
                        nxt.st   = rsd_pkg::ST_RECV;
                        nxt.cnt  = 8'h01;
                        nxt.nblk = nlen;                               // see RQ5
                        nxt.syn  = syn_upd;
                        nxt.lam  = erase_eff ? er_lam : lam_base;
                        nxt.ers  = erase_eff ? 8'h01 : 8'h00;          // see RQ4
                        nxt.xpos = gf_mul(x0, ALPHA_INV);
                    end
                end
                rsd_pkg::ST_RECV: begin
                    // A marker here is just another symbol, see RQ2
                    nxt.syn  = syn_upd;
                    nxt.xpos = gf_mul(cur.xpos, ALPHA_INV);
                    nxt.cnt  = cur.cnt + 8'h01;
                    if (erase_eff) begin
                        nxt.ers = cur.ers + 8'h01;
                        // Locator degree is capped; overflow is reported as failure
                        if (cur.ers < 8'(PAR)) begin
                            nxt.lam = er_lam;
                        end
                    end
                    if (cur.cnt == cur.nblk - 8'h01) begin
                        nxt.st  = (nxt.ers >= 8'(PAR)) ? rsd_pkg::ST_OMEGA : rsd_pkg::ST_BM;
                        nxt.kit = (nxt.ers >= 8'(PAR)) ? 8'h00 : nxt.ers;
                        nxt.len = nxt.ers;
                        nxt.gam = 8'h01;
                        nxt.bb  = nxt.lam;
                    end
                end
                rsd_pkg::ST_BM: begin
                    // Erasure-seeded iterations, see RQ17
                    nxt.lam = bm_lam;
                    if ((dot != 8'h00) &&
                        ({cur.len, 1'b0} <= ({1'b0, cur.kit} + {1'b0, cur.ers}))) begin
                        nxt.bb  = cur.lam;
                        nxt.len = cur.kit + 8'h01 + cur.ers - cur.len;
                        nxt.gam = dot;
                    end else begin
                        nxt.bb = {cur.bb[PAR-1:0], 8'h00};
                    end
                    nxt.kit = cur.kit + 8'h01;
                    if (cur.kit == 8'(PAR - 1)) begin
                        nxt.st  = rsd_pkg::ST_OMEGA;
                        nxt.kit = 8'h00;
                    end
                end
                rsd_pkg::ST_OMEGA: begin
                    nxt.omg[cur.kit[$clog2(PAR)-1:0]] = dot;
                    nxt.synz = |cur.syn;
                    nxt.kit  = cur.kit + 8'h01;
                    if (cur.kit == 8'(PAR - 1)) begin
                        nxt.st  = rsd_pkg::ST_SEEK;
                        nxt.cl  = cur.lam;
                        nxt.co  = nxt.omg;
                        // Steps from alpha^0 to the first symbol's point
                        nxt.cnt = 8'h00 - cur.nblk;
                    end
                end
                rsd_pkg::ST_SEEK: begin
                    nxt.cl  = cl_step;
                    nxt.co  = co_step;
                    nxt.cnt = cur.cnt - 8'h01;
                    if (cur.cnt == 8'h01) begin
                        nxt.st    = rsd_pkg::ST_OUT;
                        nxt.cnt   = 8'h00;
                        nxt.roots = 8'h00;
                        nxt.nerr  = 8'h00;
                        nxt.nera  = 8'h00;
                    end
                end
                rsd_pkg::ST_OUT: begin
                    nxt.p_vld   = 1'b1;
                    nxt.p_root  = (lam_val == 8'h00);
                    nxt.p_err   = (lam_val == 8'h00) ?
                                  gf_mul(om_val, gf_pow(odd_val, INV_EXP)) : 8'h00;
                    nxt.p_first = (cur.cnt == 8'h00);
                    nxt.p_last  = (cur.cnt == cur.nblk - 8'h01);
                    nxt.roots   = cur.roots + {7'h00, lam_val == 8'h00};
                    nxt.cl      = cl_step;
                    nxt.co      = co_step;
                    nxt.cnt     = cur.cnt + 8'h01;
                    if (cur.cnt == cur.nblk - 8'h01) begin
                        nxt.st = rsd_pkg::ST_IDLE;
                    end
                end
            endcase
            nxt.rdy  = (nxt.st == rsd_pkg::ST_IDLE) || (nxt.st == rsd_pkg::ST_RECV); // see RQ14
            nxt.frdy = (nxt.st == rsd_pkg::ST_IDLE);                   // see RQ15
        end
    end

    // Upstream must hold reset one cycle before sending, see RQ3
    always_ff @(posedge clk) begin
        if (clr) begin
            cur        <= '0;
            cur.rdy    <= `RSD_RST_READY;
            cur.frdy   <= `RSD_RST_FIRST;
            cur.bend_n <= `RSD_RST_BEND_N;
        end else begin
            cur <= nxt;
        end
    end

    assign data_out    = cur.dout;
    assign data_del    = cur.ddel;
    assign out_valid   = cur.ovalid;
    assign blk_start   = cur.bstart;
    assign blk_end_n   = cur.bend_n;
    assign status      = cur.stat;
    assign ready       = cur.rdy;
    assign first_ready = cur.frdy;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    localparam int BM_MAX = PAR;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence seq_start;
        cur.st == rsd_pkg::ST_IDLE && en && sync;
    endsequence
    sequence seq_first_issue;
        cur.st == rsd_pkg::ST_OUT && en && cur.cnt == 8'h00 ##1 en;
    endsequence
    sequence seq_last_issue;
        cur.st == rsd_pkg::ST_OUT && en && cur.cnt == cur.nblk - 8'h01 ##1 en;
    endsequence

    chk_drop_idle: assert property (cur.st == rsd_pkg::ST_IDLE && en && !sync && !sync_clear
        |=> cur.st == rsd_pkg::ST_IDLE) else $error("symbol taken without marker"); // see RQ1
    chk_sync_ignored: assert property ((cur.st inside {rsd_pkg::ST_BM, rsd_pkg::ST_SEEK}) && sync
        |=> cur.st != rsd_pkg::ST_RECV) else $error("marker accepted while busy"); // see RQ2
    chk_len_sample: assert property (seq_start ##0 !sync_clear |=> cur.nblk == $past(nlen))
        else $error("block length not sampled"); // see RQ5
    chk_clear_init: assert property (sync_clear |=> cur.st == rsd_pkg::ST_IDLE && ready
        && first_ready && !out_valid) else $error("clear left state behind"); // see RQ6
    chk_corr_value: assert property (cur.p_vld && en && !sync_clear
        |=> data_out == (data_del ^ $past(cur.p_err))) else $error("correction mismatch"); // see RQ7
    chk_start_first: assert property (seq_first_issue ##0 !sync_clear |=> blk_start && out_valid)
        else $error("start flag missing"); // see RQ8
    chk_end_low: assert property (seq_last_issue ##0 !sync_clear |=> !blk_end_n && out_valid)
        else $error("end flag not low"); // see RQ9
    chk_found_erase: assert property (!blk_end_n && status.erase_cnt != 8'h00
        |-> status.err_found) else $error("erasures without found flag"); // see RQ10
    chk_fail_over: assert property (!blk_end_n && status.erase_cnt > 8'(PAR) |-> status.fail)
        else $error("too many erasures not failed"); // see RQ12
    chk_ready_pair: assert property (first_ready |-> ready && cur.st == rsd_pkg::ST_IDLE)
        else $error("first-ready without ready"); // see RQ15
    chk_bm_bound: assert property ($rose(cur.st == rsd_pkg::ST_BM) && en
        |-> ##[1:BM_MAX] cur.st == rsd_pkg::ST_OMEGA || !en || sync_clear)
        else $error("locator search overran"); // see RQ17
    chk_hold_en: assert property (!en && !sync_clear |=> $stable(data_out) && $stable(cur.st)
        && $stable(cur.cnt) && $stable(ready)) else $error("state moved while disabled"); // see RQ23
endmodule : reed_solomon_block_decoder

// ==== src/rsd_defs.svh ====
/*
 * Constants of the block decoder: code shape, field, options, reset values.
 * Assumes it is included by its bare name; macros only, no logic.
 */
`ifndef RSD_DEFS_SVH
`define RSD_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Symbol field
`define RSD_SYM_W        8
`define RSD_POLY_SEL     9'h000
`define RSD_POLY_DEF     9'h11d
`define RSD_ALPHA        8'h02

////////////////////////////////////////////////////////////////////////////////
// Preset codes, n then k
`define RSD_ATSC_N       207
`define RSD_ATSC_K       187
`define RSD_CCSDS_N      255
`define RSD_CCSDS_K      223
`define RSD_DVB_N        204
`define RSD_DVB_K        188
`define RSD_SAT126_N     126
`define RSD_SAT126_K     112
`define RSD_SAT194_N     194
`define RSD_SAT194_K     178
`define RSD_SAT208_N     208
`define RSD_SAT208_K     192
`define RSD_SAT219_N     219
`define RSD_SAT219_K     201
`define RSD_SAT225_N     225
`define RSD_SAT225_K     205
`define RSD_WMAN_N       255
`define RSD_WMAN_K       239

// Code in use
`define RSD_N            `RSD_WMAN_N
`define RSD_K            `RSD_WMAN_K

////////////////////////////////////////////////////////////////////////////////
// Options
`define RSD_OPT_ERASE    1'b1
`define RSD_OPT_VARN     1'b1
`define RSD_OPT_SRST     1'b1
`define RSD_OPT_DEL      1'b1
`define RSD_CHANNELS     1
`define RSD_CLK_PER_SYM  1

////////////////////////////////////////////////////////////////////////////////
// Reset values of the output flags
`define RSD_RST_READY    1'b1
`define RSD_RST_FIRST    1'b1
`define RSD_RST_BEND_N   1'b1

`endif

// ==== src/rsd_pkg.sv ====
/*
 * Types of the block decoder: state encoding, symbol, status carrier and
 * the decoder's whole state record.
 * Assumes rsd_defs.svh sits beside it.
 */
package rsd_pkg;
`include "rsd_defs.svh"

    localparam int SYM_W = `RSD_SYM_W;
    localparam int PAR   = `RSD_N - `RSD_K;
    localparam int CNT_W = $clog2(PAR + 1);

    typedef logic [SYM_W-1:0] sym_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_RECV  = 3'h1,
        ST_BM    = 3'h3,
        ST_OMEGA = 3'h2,
        ST_SEEK  = 3'h6,
        ST_OUT   = 3'h7
    } state_e;

    typedef struct packed {
        logic             err_found;
        logic [CNT_W-1:0] err_cnt;
        logic             fail;
        sym_t             erase_cnt;
    } blk_status_s;

    typedef struct packed {
        state_e           st;
        sym_t             cnt;
        sym_t             nblk;
        sym_t             xpos;
        sym_t             ers;
        sym_t             len;
        sym_t             kit;
        sym_t             gam;
        sym_t [PAR-1:0]   syn;
        sym_t [PAR:0]     lam;
        sym_t [PAR:0]     bb;
        sym_t [PAR-1:0]   omg;
        sym_t [PAR:0]     cl;
        sym_t [PAR-1:0]   co;
        logic             synz;
        sym_t             roots;
        sym_t             nerr;
        sym_t             nera;
        logic             p_vld;
        logic             p_root;
        logic             p_first;
        logic             p_last;
        sym_t             p_err;
        sym_t             dout;
        sym_t             ddel;
        logic             bstart;
        logic             bend_n;
        logic             ovalid;
        logic             rdy;
        logic             frdy;
        blk_status_s      stat;
    } dec_st_s;

endpackage : rsd_pkg

// ==== src/rsd_symbol_ram.sv ====
/*
 * Block store: one received symbol plus its erasure flag per entry.
 * Assumes one clock; read data are registered and advance only on rd_en.
 */
`timescale 1ns/1ns
`include "rsd_defs.svh"
module rsd_symbol_ram (
    input  wire logic                 clk,     // Sample clock
    input  wire logic                 wr_en,   // Write strobe
    input  wire rsd_pkg::sym_t        wr_addr, // Write position
    input  wire logic [`RSD_SYM_W:0]  wr_data, // Flag and symbol
    input  wire logic                 rd_en,   // Read advance
    input  wire rsd_pkg::sym_t        rd_addr, // Read position
    output logic      [`RSD_SYM_W:0]  rd_data  // Registered read word
);
    logic [`RSD_SYM_W:0] mem [2**`RSD_SYM_W];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : rsd_symbol_ram
